// [core/gpio_port_pkg.sv]
// Shared constants and encodings for the eight-pin port.
// Assumes a single clock domain and a synchronous active-low reset.
package gpio_port_pkg;
	localparam int PIN_COUNT = 8;
	localparam int PIN_INDEX_W = 3;
	localparam int SENSE_W = 3;
	localparam int DRIVE_W = 2;
	localparam int PAD_W = 3;
	localparam int FUNC_W = 4;
	localparam int SYNC_STAGES = 2;

	typedef logic [SENSE_W-1:0] sense_t;
	typedef logic [DRIVE_W-1:0] drive_t;
	typedef logic [PAD_W-1:0] pad_t;
	typedef logic [FUNC_W-1:0] func_t;

	// Interrupt sense codes, read back as written
	localparam sense_t sense_falling = 3'h0;
	localparam sense_t sense_rising = 3'h1;
	localparam sense_t sense_both = 3'h2;
	localparam sense_t sense_low = 3'h3;
	localparam sense_t sense_high = 3'h4;

	// Drive strength codes
	localparam drive_t drive_2ma = 2'h0;
	localparam drive_t drive_4ma = 2'h1;
	localparam drive_t drive_8ma = 2'h2;
	localparam drive_t drive_8ma_slew_limited = 2'h3;

	// Pad type codes
	localparam pad_t pad_push_pull = 3'h0;
	localparam pad_t pad_push_pull_pullup = 3'h1;
	localparam pad_t pad_push_pull_pulldown = 3'h2;
	localparam pad_t pad_open_drain = 3'h3;
	localparam pad_t pad_open_drain_pullup = 3'h4;
	localparam pad_t pad_open_drain_pulldown = 3'h5;
	localparam pad_t pad_analog = 3'h6;

	// Function code zero leaves the pin as plain port logic
	localparam func_t func_none = 4'h0;

	// Reset values
	localparam sense_t sense_reset = sense_falling;
	localparam drive_t drive_reset = drive_2ma;
	localparam pad_t pad_reset = pad_push_pull;
	localparam logic [PIN_COUNT-1:0] mask_reset = 8'h00;
endpackage

// [core/pin_event_if.sv]
// Carries per-pin levels, senses and detector results between port and detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pin_event_if
	import gpio_port_pkg::*;
	#(parameter int N = PIN_COUNT);
	logic [N-1:0] level;
	sense_t [N-1:0] sense;
	logic [N-1:0] clear;
	logic [N-1:0] raw;
	logic [N-1:0] event_pulse;
	modport port (output level, output sense, output clear, input raw, input event_pulse);
	modport detect (input level, input sense, input clear, output raw, output event_pulse);
endinterface

// [core/pin_event_detect.sv]
// Per-pin edge and level detection with sticky edge flags.
// Assumes levels arrive already synchronised to clk.
`timescale 1ns/1ps
module pin_event_detect
	import gpio_port_pkg::*;
	#(parameter int N = PIN_COUNT)
	(
	input wire logic clk,
	input wire logic resetn,
	pin_event_if.detect ev
	);

	logic [N-1:0] prev_reg;
	logic [N-1:0] latch_reg;
	logic [N-1:0] edge_hit;
	logic [N-1:0] level_hit;
	logic [N-1:0] level_was;
	logic [N-1:0] is_level;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= ev.level;
		end
	end

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pin
			always_comb begin
				edge_hit[i] = 1'b0;
				level_hit[i] = 1'b0;
				level_was[i] = 1'b0;
				is_level[i] = 1'b0;
				case (ev.sense[i])
					sense_falling: edge_hit[i] = prev_reg[i] & ~ev.level[i];
					sense_rising: edge_hit[i] = ~prev_reg[i] & ev.level[i];
					sense_both: edge_hit[i] = prev_reg[i] ^ ev.level[i];
					sense_low: begin
						is_level[i] = 1'b1;
						level_hit[i] = ~ev.level[i];
						level_was[i] = ~prev_reg[i];
					end
					sense_high: begin
						is_level[i] = 1'b1;
						level_hit[i] = ev.level[i];
						level_was[i] = prev_reg[i];
					end
					default: edge_hit[i] = 1'b0;
				endcase
			end

			always_ff @(posedge clk) begin
				if (!resetn) begin
					latch_reg[i] <= 1'b0;
				end else if (edge_hit[i]) begin
					latch_reg[i] <= 1'b1;
				end else if (ev.clear[i] || is_level[i]) begin
					latch_reg[i] <= 1'b0;
				end
			end

			assign ev.raw[i] = is_level[i] ? level_hit[i] : latch_reg[i];
			assign ev.event_pulse[i] = edge_hit[i] | (level_hit[i] & ~level_was[i]);
		end
	endgenerate

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sticky_edge_a: assert property (latch_reg[0] && !ev.clear[0] && !is_level[0] |=> latch_reg[0])
		else $error("edge flag dropped without clear");
	set_wins_a: assert property (edge_hit[1] |=> latch_reg[1])
		else $error("edge lost against clear");
	level_follow_a: assert property (ev.sense[2] == sense_high |-> ev.raw[2] == ev.level[2])
		else $error("high level status not following pin");
endmodule

// [core/gpio_port.sv]
// Eight-pin port: interrupt sense, masking, DMA triggers, pad and mux settings.
// Assumes command strobes come from logic on clk; pin inputs are asynchronous.
`timescale 1ns/1ps
module gpio_port
	import gpio_port_pkg::*;
	#(parameter int N = PIN_COUNT)
	(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [N-1:0] pin_in,
	input wire logic [N-1:0] pin_select_mask,
	input wire logic [PIN_INDEX_W-1:0] pin_index,
	input wire logic dma_enable_wr,
	input wire logic dma_disable_wr,
	input wire logic int_enable_wr,
	input wire logic int_disable_wr,
	input wire logic int_clear_wr,
	input wire logic sense_wr,
	input wire sense_t interrupt_sense_select,
	input wire logic pad_wr,
	input wire drive_t drive_strength_select,
	input wire pad_t pad_type_select,
	input wire logic function_wr,
	input wire func_t pin_function_code,
	input wire logic status_masked_select,
	input wire logic [N-1:0] pin_read_mask,
	output logic [N-1:0] pin_read_data,
	output logic [N-1:0] int_status,
	output logic [N-1:0] int_line,
	output logic [N-1:0] dma_request,
	output sense_t sense_readback,
	output drive_t drive_readback,
	output pad_t pad_type_readback,
	output func_t function_readback,
	output drive_t [N-1:0] pad_drive,
	output pad_t [N-1:0] pad_type,
	output func_t [N-1:0] function_select,
	output logic [N-1:0] dma_enable,
	output logic [N-1:0] int_mask
	);

	logic [N-1:0] sync1_reg;
	logic [N-1:0] sync2_reg;
	sense_t [N-1:0] sense_reg;
	drive_t [N-1:0] drive_reg;
	pad_t [N-1:0] pad_reg;
	func_t [N-1:0] func_reg;
	logic [N-1:0] dma_en_reg;
	logic [N-1:0] mask_reg;
	logic [N-1:0] read_reg;
	logic [N-1:0] status_reg;
	logic [N-1:0] line_reg;
	logic [N-1:0] dma_req_reg;
	sense_t sense_rb_reg;
	drive_t drive_rb_reg;
	pad_t pad_rb_reg;
	func_t func_rb_reg;

	pin_event_if #(.N(N)) ev ();

	pin_event_detect #(.N(N)) u_detect (
		.clk(clk),
		.resetn(resetn),
		.ev(ev)
	);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
		end
	end

	assign ev.level = sync2_reg;
	assign ev.sense = sense_reg;
	assign ev.clear = int_clear_wr ? pin_select_mask : '0;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_cfg
			always_ff @(posedge clk) begin
				if (!resetn) begin
					sense_reg[i] <= sense_reset;
				end else if (sense_wr && pin_select_mask[i]) begin
					sense_reg[i] <= interrupt_sense_select;
				end
			end

			always_ff @(posedge clk) begin
				if (!resetn) begin
					drive_reg[i] <= drive_reset;
					pad_reg[i] <= pad_reset;
				end else if (pad_wr && pin_select_mask[i]) begin
					drive_reg[i] <= drive_strength_select;
					pad_reg[i] <= pad_type_select;
				end
			end

			always_ff @(posedge clk) begin
				if (!resetn) begin
					func_reg[i] <= func_none;
				end else if (function_wr && pin_index == PIN_INDEX_W'(i)) begin
					func_reg[i] <= pin_function_code;
				end
			end

			always_ff @(posedge clk) begin
				if (!resetn) begin
					dma_en_reg[i] <= mask_reset[i];
				end else if (dma_disable_wr && pin_select_mask[i]) begin
					dma_en_reg[i] <= 1'b0;
				end else if (dma_enable_wr && pin_select_mask[i]) begin
					dma_en_reg[i] <= 1'b1;
				end
			end

			always_ff @(posedge clk) begin
				if (!resetn) begin
					mask_reg[i] <= mask_reset[i];
				end else if (int_disable_wr && pin_select_mask[i]) begin
					mask_reg[i] <= 1'b0;
				end else if (int_enable_wr && pin_select_mask[i]) begin
					mask_reg[i] <= 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!resetn) begin
			dma_req_reg <= '0;
		end else begin
			dma_req_reg <= ev.event_pulse & dma_en_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			status_reg <= '0;
			line_reg <= '0;
		end else begin
			status_reg <= status_masked_select ? (ev.raw & mask_reg) : ev.raw;
			line_reg <= ev.raw & mask_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			read_reg <= '0;
		end else begin
			read_reg <= sync2_reg & pin_read_mask;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sense_rb_reg <= sense_reset;
			drive_rb_reg <= drive_reset;
			pad_rb_reg <= pad_reset;
			func_rb_reg <= func_none;
		end else begin
			sense_rb_reg <= sense_reg[pin_index];
			drive_rb_reg <= drive_reg[pin_index];
			pad_rb_reg <= pad_reg[pin_index];
			func_rb_reg <= func_reg[pin_index];
		end
	end

	// Outputs come straight from flops; readback lags the index by one cycle
	assign pin_read_data = read_reg;
	assign int_status = status_reg;
	assign int_line = line_reg;
	assign dma_request = dma_req_reg;
	assign sense_readback = sense_rb_reg;
	assign drive_readback = drive_rb_reg;
	assign pad_type_readback = pad_rb_reg;
	assign function_readback = func_rb_reg;
	assign pad_drive = drive_reg;
	assign pad_type = pad_reg;
	assign function_select = func_reg;
	assign dma_enable = dma_en_reg;
	assign int_mask = mask_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence sense_write_s;
		sense_wr && pin_select_mask[0] ##1 pin_index == 3'h0;
	endsequence

	sequence pad_write_s;
		pad_wr && pin_select_mask[3] ##1 pin_index == 3'h3;
	endsequence

	// Sense written then read back two cycles after the write
	sense_readback_a: assert property (sense_write_s |=> sense_readback == $past(interrupt_sense_select, 2))
		else $error("sense readback differs from written code");

	pad_readback_a: assert property (pad_write_s |=>
		drive_readback == $past(drive_strength_select, 2) && pad_type_readback == $past(pad_type_select, 2))
		else $error("pad readback differs from written code");

	dma_request_a: assert property (ev.event_pulse[0] && dma_en_reg[0] |=> dma_request[0])
		else $error("enabled event gave no dma request");

	dma_disabled_a: assert property (dma_disable_wr && pin_select_mask[0] ##1 1'b1 |=> !dma_request[0])
		else $error("disabled pin still requests dma");

	masked_line_a: assert property (int_line[0] |-> $past(mask_reg[0]))
		else $error("interrupt raised on masked pin");

	// Only a plain enable; a disable in the same cycle wins
	enable_sets_a: assert property (dma_enable_wr && !dma_disable_wr && pin_select_mask[0] |=> dma_enable[0])
		else $error("trigger enable not stored");

	request_enabled_a: assert property (dma_request[2] |-> $past(dma_en_reg[2]))
		else $error("dma request from disabled pin");

	unmask_sets_a: assert property (int_enable_wr && !int_disable_wr && pin_select_mask[0] |=> int_mask[0])
		else $error("interrupt unmask not stored");

	raw_status_a: assert property (!status_masked_select |=> int_status == $past(ev.raw))
		else $error("raw status differs from detector");

	function_write_a: assert property (function_wr && pin_index == 3'h5 |=>
		function_select[5] == $past(pin_function_code))
		else $error("function code not stored for indexed pin");

	// A new edge in the same cycle keeps the flag set
	clear_selected_a: assert property (int_clear_wr && pin_select_mask[1] && !u_detect.edge_hit[1] &&
		!u_detect.is_level[1] |=> !u_detect.latch_reg[1])
		else $error("clear missed selected pin");

	unselected_mask_a: assert property (sense_wr && !pin_select_mask[5] |=> $stable(sense_reg[5]))
		else $error("unselected pin sense changed");

	read_zero_a: assert property (!$past(pin_read_mask[6]) |-> !pin_read_data[6])
		else $error("unselected pin read nonzero");

	sync_delay_a: assert property (pin_in[7] ##1 pin_in[7] |=> sync2_reg[7])
		else $error("pin level not through two stages");

	masked_status_a: assert property (status_masked_select && !mask_reg[1] |=> !int_status[1])
		else $error("masked status shows masked pin");

	clear_keep_a: assert property (int_clear_wr && !pin_select_mask[6] && u_detect.latch_reg[6] &&
		!u_detect.is_level[6] |=>
		u_detect.latch_reg[6])
		else $error("clear hit unselected pin");

	reset_off_a: assert property (disable iff (1'b0) !resetn |=> dma_enable == '0 && int_mask == '0 &&
		function_select == '0)
		else $error("control not inactive after reset");
endmodule

// [verification/pin_pad_model.sv]
// External pin drivers seen by the port.
// Assumes the bench sets the wanted levels; pins move on falling edges only.
`timescale 1ns/1ps
module pin_pad_model (
	input wire logic clk,
	input wire logic [7:0] want,
	output logic [7:0] pin_in
	);
	initial pin_in = 8'h00;
	always @(negedge clk) begin
		pin_in <= want;
	end
endmodule

// [verification/test_gpio_port_irq_trigger_pad.sv]
// Self-checking bench for gpio_port against a reference model.
// Assumes pin_pad_model drives the pins; inputs change on falling edges.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: got %0h exp %0h", $time, a, b); end end
module test_gpio_port_irq_trigger_pad;
	import gpio_port_pkg::*;
	logic clk = 0;
	logic resetn = 0;
	logic [7:0] want = 8'h00;
	logic [7:0] psel = 8'h00;
	logic [7:0] rmask = 8'h00;
	logic [7:0] stb = 8'h00;
	logic [2:0] idx = 3'h0;
	logic msel = 0;
	sense_t ssel = 3'h0;
	drive_t dsel = 2'h0;
	pad_t tsel = 3'h0;
	func_t fcode = 4'h0;
	wire logic [7:0] pins;
	logic [7:0] rdata, ist, iline, dreq, dma_en, imask, seen;
	sense_t srb;
	drive_t drb;
	pad_t prb;
	func_t frb;
	drive_t [7:0] pdrv;
	pad_t [7:0] ptyp;
	func_t [7:0] fsel;
	int sense_m[8], drive_m[8], pad_m[8], func_m[8];
	int seed = 42004;
	int errors = 0;
	int cmp_count = 0;
	int i, n, s, base;
	// Expected status per sense code after a rise, then after a fall
	logic [4:0] after_rise = 5'h16;
	logic [4:0] after_fall = 5'h0F;

	always #2 clk = ~clk;

	pin_pad_model pads (.clk(clk), .want(want), .pin_in(pins));

	gpio_port uut (.clk(clk), .resetn(resetn), .pin_in(pins), .pin_select_mask(psel), .pin_index(idx),
		.dma_enable_wr(stb[0]), .dma_disable_wr(stb[1]), .int_enable_wr(stb[2]), .int_disable_wr(stb[3]),
		.int_clear_wr(stb[4]), .sense_wr(stb[5]), .interrupt_sense_select(ssel), .pad_wr(stb[6]),
		.drive_strength_select(dsel), .pad_type_select(tsel), .function_wr(stb[7]), .pin_function_code(fcode),
		.status_masked_select(msel), .pin_read_mask(rmask), .pin_read_data(rdata), .int_status(ist),
		.int_line(iline), .dma_request(dreq), .sense_readback(srb), .drive_readback(drb),
		.pad_type_readback(prb), .function_readback(frb), .pad_drive(pdrv), .pad_type(ptyp),
		.function_select(fsel), .dma_enable(dma_en), .int_mask(imask));

	task summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task cmd(input int k, input logic [7:0] m);
		psel = m;
		stb = 8'h01 << k;
		@(negedge clk);
		stb = 8'h00;
		// Idle cycle so back-to-back commands never rewrite the strobes at once
		@(negedge clk);
	endtask

	// Counts request pulses while pins rise; one pulse is one transfer
	task raise_count(input logic [7:0] lv);
		seen = 8'h00;
		n = 0;
		want = lv;
		repeat (10) begin
			@(negedge clk);
			seen |= dreq;
			n += $countones(dreq);
		end
	endtask

	initial begin
		#100000;
		errors++;
		summarize;
	end

	initial begin
		repeat (20) @(negedge clk);
		resetn = 1;
		@(negedge clk);
		`CHK(dma_en, 8'h00)
		`CHK(imask, 8'h00)
		`CHK(fsel, 32'h00000000)
		$display("reset values done");
		// each function routed to one pin
		base = $unsigned($random(seed)) % 15;
		for (i = 0; i < 8; i++) begin
			sense_m[i] = $unsigned($random(seed)) % 5;
			drive_m[i] = $unsigned($random(seed)) % 4;
			pad_m[i] = $unsigned($random(seed)) % 7;
			func_m[i] = (base + i) % 15 + 1;
			ssel = sense_t'(sense_m[i]);
			dsel = drive_t'(drive_m[i]);
			tsel = pad_t'(pad_m[i]);
			fcode = func_t'(func_m[i]);
			idx = i[2:0];
			cmd(5, 8'h01 << i);
			cmd(6, 8'h01 << i);
			cmd(7, 8'h00);
		end
		for (i = 0; i < 8; i++) begin
			idx = i[2:0];
			repeat (2) @(negedge clk);
			`CHK(srb, sense_t'(sense_m[i]))
			`CHK(drb, drive_t'(drive_m[i]))
			`CHK(prb, pad_t'(pad_m[i]))
			`CHK(frb, func_t'(func_m[i]))
			`CHK(pdrv[i], drive_t'(drive_m[i]))
			`CHK(ptyp[i], pad_t'(pad_m[i]))
		end
		$display("config readback done");
		repeat (4) begin
			want = 8'($random(seed));
			repeat (4) @(negedge clk);
			rmask = 8'($random(seed));
			@(negedge clk);
			`CHK(rdata, want & rmask)
		end
		$display("masked read done");
		want = 8'h00;
		ssel = sense_rising;
		cmd(5, 8'hFF);
		repeat (4) @(negedge clk);
		cmd(4, 8'hFF);
		cmd(0, 8'h05);
		cmd(2, 8'h01);
		raise_count(8'h07);
		`CHK(seen, 8'h05)
		`CHK(n, 2)
		`CHK(ist, 8'h07)
		`CHK(iline, 8'h01)
		msel = 1;
		@(negedge clk);
		`CHK(ist, 8'h01)
		msel = 0;
		// clear issued well before status is trusted
		cmd(4, 8'h06);
		repeat (2) @(negedge clk);
		`CHK(ist, 8'h01)
		cmd(1, 8'h01);
		want = 8'h00;
		repeat (4) @(negedge clk);
		raise_count(8'h07);
		`CHK(seen, 8'h04)
		$display("dma and clear done");
		for (s = 0; s < 5; s++) begin
			want = 8'h00;
			repeat (4) @(negedge clk);
			ssel = sense_t'(s);
			cmd(5, 8'h10);
			cmd(4, 8'h10);
			want = 8'h10;
			repeat (6) @(negedge clk);
			`CHK(ist[4], after_rise[s])
			want = 8'h00;
			repeat (6) @(negedge clk);
			`CHK(ist[4], after_fall[s])
		end
		$display("sense codes done");
		summarize;
	end
endmodule
